// *** hdl/frtic_pkg.sv ***
// constants for the free-running timer with input capture
package frtic_pkg;
    localparam logic [7:0]  OFF_COUNT = 8'h00;    // counter, read only
    localparam logic [7:0]  OFF_PULSE_ACCUM_CONTROL_REG = 8'h04;    // pulse_accum_control_reg
    localparam logic [7:0]  OFF_EDGE  = 8'h08;    // capture_edge_control_reg
    localparam logic [7:0]  OFF_FLAG  = 8'h0C;    // timer_flag_reg_one, w1c
    localparam logic [7:0]  OFF_MASK  = 8'h10;    // timer_mask_reg_one
    localparam logic [7:0]  OFF_PORT  = 8'h14;    // port_a_data_reg
    localparam logic [7:0]  OFF_CAPT  = 8'h18;    // capture 1..4, word apart
    localparam logic [7:0]  OFF_CMP   = 8'h28;    // compare 1..4, word apart
    // pulse_accum_control_reg fields
    localparam int          PA_PRE    = 0;        // prescale_select [1:0]
    localparam int          PA_SEL    = 2;        // capture4_compare5_select
    localparam int          PA_DIR    = 3;        // shared_pin_direction_bit
    // flag / mask layout
    localparam int          FL_IC     = 0;        // capture 1..4 at [3:0]
    localparam int          FL_OC5    = 4;        // shared compare
    localparam int          FL_OC     = 5;        // compare 1..4 at [8:5]
    localparam int          FL_OVF    = 9;        // counter overflow
    localparam int          NFLAG     = 10;
    // reset values and counts
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CMP_RST   = 16'hFFFF;
    localparam logic [1:0]  BLK_CYC   = 2'h2;     // one bus cycle = two clocks
endpackage : frtic_pkg

// *** hdl/frtic_timer.sv ***
// free-running 16-bit timer with input capture, compare match and bus slave
//
// Notes on behaviour
// - bus clock divided by 1, 4, 8 or 16 per prescale_select 00..11
// - 16-bit counter counts up from zero after reset
// - at all-ones it wraps to zero, sets overflow flag, keeps counting
// - software cannot reset, load, alter or stop the counter
// - three capture, four compare, one shared capture/compare channel
// - each capture channel has its own 16-bit latch register
// - every timer event has its own enable and its own vector line
// - selected edge on a channel pin copies counter into its latch
// - edges synchronised; latch on phase opposite to counter increment
// - pin levels of the four capture pins readable in port register
// - select bit set: shared pin is capture four; clear: compare five
// - shared pin direction bit resets to zero, pin is an input
// - shared pin as output with capture four on: written edges capture
// - writes to the shared register ignored while it is capture four
// - pin owned by compare function ignores general-purpose writes
// - edge pair: 00 off, 01 rising, 10 falling, 11 either edge
// - high-byte capture read blocks transfer one bus cycle, not lost
// - reset leaves capture registers unchanged
`timescale 1ns/100ps
`default_nettype none
module frtic_timer
    import frtic_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [2:0]        capture_pin_in,
    input  wire logic              shared_channel_pin_in,
    output logic                   shared_channel_pin_out,
    output logic                   shared_channel_pin_oe_n,
    output logic [NFLAG-1:0]       irq_vector,
    output logic                   irq
);
    typedef struct packed {
        logic [15:0]             cnt;
        logic                    phase;      // phase_two_clock
        logic [3:0]              pdiv;
        logic                    tickd;      // counter moved last cycle
        logic [1:0]              presc;
        logic                    sel;
        logic                    dir;
        logic [7:0]              edge_sel;
        logic                    pout;
        logic [NFLAG-1:0]        flag;
        logic [NFLAG-1:0]        mask;
        logic [3:0][15:0]        capt;
        logic [3:0][15:0]        cmp;
        logic [3:0][2:0]         sync;
        logic [3:0]              lvl;
        logic [3:0]              pend;
        logic [1:0]              blk;
        logic                    ack;
        logic [31:0]             rdata;
    } frtic_state_s;

    frtic_state_s q;
    frtic_state_s d;
    logic [3:0]   pin_raw;
    logic [3:0]   limit;
    logic         inc;
    logic         req;
    logic [3:0]   ch_on;

    assign pin_raw = {shared_channel_pin_in, capture_pin_in};
    assign req     = avs_read | avs_write;

    // prescale limit: divide bus cycles by 1, 4, 8 or 16
    always_comb begin
        case (q.presc)
            2'b00:   limit = 4'h0;
            2'b01:   limit = 4'h3;
            2'b10:   limit = 4'h7;
            default: limit = 4'hF;
        endcase
    end

    // counter advances on the high half of the phase clock only
    assign inc = q.phase & (q.pdiv >= limit);

    // channel enables; the shared channel captures only when selected
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ch_on[i] = (q.edge_sel[2*i +: 2] != 2'b00);
        end
        ch_on[3] = ch_on[3] & q.sel;
    end

    // next-state logic: counter, capture, compare, registers
    always_comb begin
        logic       lv;
        logic [4:0] wi;
        d = q;
        lv = 1'b0;
        wi = 5'h00;
        // write one to clear first, so any set later in this cycle wins
        if (q.ack && avs_write && avs_address == OFF_FLAG) begin
            d.flag = q.flag & ~avs_writedata[NFLAG-1:0];
        end
        // phase clock and prescaler
        d.phase = ~q.phase;
        d.tickd = inc;
        if (q.phase) begin
            d.pdiv = (q.pdiv >= limit) ? 4'h0 : q.pdiv + 4'h1;
        end
        if (inc) begin
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt == CNT_MAX) begin
                d.flag[FL_OVF] = 1'b1;
            end
        end
        // synchronise pins and detect edges
        for (int i = 0; i < 4; i++) begin
            d.sync[i] = {q.sync[i][1:0], pin_raw[i]};
            lv = (q.sync[i][1] == q.sync[i][2]) ? q.sync[i][2] : q.lvl[i];
            if (i == 3 && q.dir) begin
                lv = q.pout;
            end
            d.lvl[i] = lv;
            if (ch_on[i] && lv != q.lvl[i]) begin
                if ((lv && q.edge_sel[2*i]) || (!lv && q.edge_sel[2*i+1])) begin
                    d.pend[i] = 1'b1;
                end
            end
        end
        // latch on the low half, unless a high-byte read blocks it
        if (q.blk != 2'h0) begin
            d.blk = q.blk - 2'h1;
        end else if (!q.phase) begin
            for (int i = 0; i < 4; i++) begin
                if (q.pend[i]) begin
                    d.capt[i]         = q.cnt;
                    d.pend[i]         = 1'b0;
                    d.flag[FL_IC + i] = 1'b1;
                end
            end
        end
        // compare match once per counter step
        if (!q.phase && q.tickd) begin
            for (int i = 0; i < 4; i++) begin
                if (q.cmp[i] == q.cnt) begin
                    d.flag[FL_OC + i] = 1'b1;
                end
            end
            if (!q.sel && q.capt[3] == q.cnt) begin
                d.flag[FL_OC5] = 1'b1;
            end
        end
        // bus: one wait cycle, access completes when ack is high
        d.ack = req & ~q.ack;
        if (req && !q.ack) begin
            case (avs_address)
                OFF_COUNT: d.rdata = {16'h0000, q.cnt};
                OFF_PULSE_ACCUM_CONTROL_REG: d.rdata = {28'h000_0000, q.dir, q.sel, q.presc};
                OFF_EDGE:  d.rdata = {24'h00_0000, q.edge_sel};
                OFF_FLAG:  d.rdata = {22'h00_0000, q.flag};
                OFF_MASK:  d.rdata = {22'h00_0000, q.mask};
                OFF_PORT:  d.rdata = {28'h000_0000, q.lvl};
                default:   d.rdata = 32'h0000_0000;
            endcase
            if (avs_address >= OFF_CAPT && avs_address < OFF_CMP + 8'h10) begin
                wi = avs_address[6:2] - OFF_CAPT[6:2];
                d.rdata = {16'h0000, wi[2] ? q.cmp[wi[1:0]] : q.capt[wi[1:0]]};
            end
        end
        if (q.ack && avs_read && avs_byteenable[1]
            && avs_address >= OFF_CAPT && avs_address < OFF_CMP) begin
            d.blk = BLK_CYC;
        end
        if (q.ack && avs_write) begin
            // the counter offset has no write path
            case (avs_address)
                OFF_PULSE_ACCUM_CONTROL_REG: begin
                    d.presc = avs_writedata[PA_PRE +: 2];
                    d.sel   = avs_writedata[PA_SEL];
                    d.dir   = avs_writedata[PA_DIR];
                end
                OFF_EDGE: d.edge_sel = avs_writedata[7:0];
                OFF_MASK: d.mask = avs_writedata[NFLAG-1:0];
                OFF_PORT: begin
                    if (q.sel) begin
                        d.pout = avs_writedata[3];
                    end
                end
                OFF_CAPT + 8'h0C: begin
                    if (!q.sel) begin
                        d.capt[3] = avs_writedata[15:0];
                    end
                end
                default: ;
            endcase
            if (avs_address >= OFF_CMP && avs_address < OFF_CMP + 8'h10) begin
                wi = avs_address[6:2] - OFF_CMP[6:2];
                d.cmp[wi[1:0]] = avs_writedata[15:0];
            end
        end
        // synchronous reset; capture latches keep their contents
        if (!rstn) begin
            d.cnt      = CNT_RST;
            d.phase    = 1'b0;
            d.pdiv     = 4'h0;
            d.tickd    = 1'b0;
            d.presc    = 2'b00;
            d.sel      = 1'b0;
            d.dir      = 1'b0;
            d.edge_sel = 8'h00;
            d.pout     = 1'b0;
            d.flag     = '0;
            d.mask     = '0;
            d.cmp      = {4{CMP_RST}};
            d.sync     = '0;
            d.lvl      = 4'h0;
            d.pend     = 4'h0;
            d.blk      = 2'h0;
            d.ack      = 1'b0;
            d.rdata    = 32'h0000_0000;
            d.capt     = q.capt;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    // outputs
    assign avs_waitrequest         = req & ~q.ack;
    assign avs_readdata            = q.rdata;
    assign shared_channel_pin_out  = q.pout;
    assign shared_channel_pin_oe_n = ~q.dir;
    assign irq_vector              = q.flag & q.mask;
    assign irq                     = |(q.flag & q.mask);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_PRESC_PHASE: assert property (
        q.cnt != $past(q.cnt) |-> $past(q.phase) && $past(q.pdiv) >= $past(limit))
        else $error("counter moved off its prescaled phase");
    AST_WRAP_OVF: assert property (
        inc && q.cnt == CNT_MAX |=> q.cnt == 16'h0000 && q.flag[FL_OVF])
        else $error("counter wrap did not clear or flag");
    AST_CNT_RESET: assert property (
        $rose(rstn) |-> q.cnt == CNT_RST)
        else $error("counter not zero after reset");
    AST_CNT_ONLY_INC: assert property (
        !inc |=> $stable(q.cnt))
        else $error("counter changed without an increment");
    AST_CAPT_PHASE: assert property (
        (q.capt[0] != $past(q.capt[0])) |-> !$past(q.phase))
        else $error("capture latched on the increment phase");
    AST_CAPT_BLOCK: assert property (
        q.blk != 2'h0 |=> $stable(q.capt[2:0]))
        else $error("capture transfer during block");
    AST_PEND_KEPT: assert property (
        q.pend[0] && q.blk != 2'h0 |=> q.pend[0])
        else $error("blocked capture was lost");
    AST_SHARED_RO: assert property (
        q.sel && q.ack && avs_write && !q.pend[3] |=> $stable(q.capt[3]))
        else $error("shared register written while capturing");
    AST_GP_BLOCKED: assert property (
        !q.sel |=> $stable(q.pout))
        else $error("compare-owned pin took a port write");
    AST_EDGE_OFF: assert property (
        q.edge_sel[1:0] == 2'b00 && !q.pend[0] |=> !q.pend[0])
        else $error("disabled channel requested a capture");
    AST_IRQ: assert property (
        $rose(q.flag[FL_IC]) && q.mask[FL_IC] |-> irq)
        else $error("unmasked capture flag without interrupt");

    // each increment adds exactly one
    AST_CNT_STEP: assert property (
        inc |=> q.cnt == $past(q.cnt) + 16'h0001)
        else $error("counter step was not one");

    // overflow flag only rises on a wrap
    AST_OVF_ONLY_WRAP: assert property (
        !q.flag[FL_OVF] && !(inc && q.cnt == CNT_MAX) |=> !q.flag[FL_OVF])
        else $error("overflow flag set without a wrap");

    // prescaler only moves on the high phase
    AST_PDIV_HOLD: assert property (
        !q.phase |=> $stable(q.pdiv))
        else $error("prescaler moved on the low phase");

    // phase clock toggles every clock
    AST_PHASE_TOGGLE: assert property (
        1'b1 |=> q.phase != $past(q.phase))
        else $error("phase clock did not toggle");

    // a fresh capture equals the still counter value
    AST_CAPT0_CNT: assert property (
        q.capt[0] != $past(q.capt[0]) |-> q.capt[0] == q.cnt)
        else $error("capture one not taken from a stable counter");

    // same for channel two
    AST_CAPT1_CNT: assert property (
        q.capt[1] != $past(q.capt[1]) |-> q.capt[1] == q.cnt)
        else $error("capture two not taken from a stable counter");

    // same for channel three
    AST_CAPT2_CNT: assert property (
        q.capt[2] != $past(q.capt[2]) |-> q.capt[2] == q.cnt)
        else $error("capture three not taken from a stable counter");

    // acknowledge lasts one cycle
    AST_ACK_ONE: assert property (
        q.ack |=> !q.ack)
        else $error("acknowledge held longer than one cycle");

    // a new request is answered on the next edge
    AST_ACK_AFTER_REQ: assert property (
        req && !q.ack |=> q.ack)
        else $error("request not answered after one wait cycle");

    // port read returns the accepted pin levels
    AST_PORT_READ: assert property (
        q.ack && avs_read && avs_address == OFF_PORT
        |-> avs_readdata == {28'h000_0000, $past(q.lvl)})
        else $error("port read did not return pin levels");

    // counter read returns the counter
    AST_COUNT_READ: assert property (
        q.ack && avs_read && avs_address == OFF_COUNT
        |-> avs_readdata == {16'h0000, $past(q.cnt)})
        else $error("counter read returned a wrong value");

    // unmapped offsets read zero
    AST_UNMAPPED_READ: assert property (
        q.ack && avs_read && avs_address >= OFF_CMP + 8'h10 |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped offset read non-zero");

    // shared pin is an input after reset
    AST_PIN_RESET: assert property (
        $rose(rstn) |-> shared_channel_pin_oe_n)
        else $error("shared pin driven after reset");

    // writing one clears a flag with no new event
    AST_FLAG_W1C: assert property (
        q.ack && avs_write && avs_address == OFF_FLAG && avs_writedata[FL_IC] && !q.pend[0]
        |=> !q.flag[FL_IC])
        else $error("capture flag not cleared by a one");

    // a latch sets its flag even against a clear
    AST_SET_WINS: assert property (
        q.pend[0] && q.blk == 2'h0 && !q.phase |=> q.flag[FL_IC])
        else $error("capture flag lost to a clear");

    // channel four stays idle while it is compare five
    AST_CAPT3_OFF: assert property (
        !q.sel && !q.pend[3] |=> !q.pend[3])
        else $error("channel four captured while compare five");

    // shared register is writable as compare five
    AST_SHARED_WR: assert property (
        !q.sel && q.ack && avs_write && avs_address == OFF_CAPT + 8'h0C && !q.pend[3]
        |=> q.capt[3] == $past(avs_writedata[15:0]))
        else $error("compare five write did not land");

    // compare registers are all ones after reset
    AST_CMP_RESET: assert property (
        $rose(rstn) |-> q.cmp[0] == CMP_RST)
        else $error("compare register not reset");

    // a high-byte capture read starts the block
    AST_BLOCK_SET: assert property (
        q.ack && avs_read && avs_byteenable[1] && avs_address == OFF_CAPT
        |=> q.blk == BLK_CYC)
        else $error("high-byte read did not block captures");

    // a disabled channel two never requests
    AST_EDGE_OFF1: assert property (
        q.edge_sel[3:2] == 2'b00 && !q.pend[1] |=> !q.pend[1])
        else $error("disabled channel two requested a capture");

    // general-purpose write lands while capture four owns the pin
    AST_GP_WRITE: assert property (
        q.sel && q.ack && avs_write && avs_address == OFF_PORT
        |=> q.pout == $past(avs_writedata[3]))
        else $error("port write to a free pin was lost");

    // a counter write changes nothing
    AST_CNT_NO_WRITE: assert property (
        q.ack && avs_write && avs_address == OFF_COUNT && !inc |=> $stable(q.cnt))
        else $error("counter took a software write");

endmodule : frtic_timer
`default_nettype wire

// *** verif/frtic_pin_model.sv ***
// pin-side model: drives the capture pins and resolves the shared pin
`timescale 1ns/100ps
`default_nettype none
module frtic_pin_model (
    input  wire logic       sys_clk,
    input  wire logic       pin_out,
    input  wire logic       pin_oe_n,
    output logic      [2:0] cap_pins,
    output logic            shared_in
);
    logic ext_lvl;
    // pins start low
    initial begin
        cap_pins = 3'h0;
        ext_lvl  = 1'b0;
    end
    // the design owns the shared wire while its enable is low
    assign shared_in = pin_oe_n ? ext_lvl : pin_out;
    // new levels for shared pin and pins 3..1, just after an edge
    task automatic drive(input logic [3:0] lvls);
        @(posedge sys_clk);
        {ext_lvl, cap_pins} <= lvls;
    endtask : drive
endmodule : frtic_pin_model
`default_nettype wire

// *** verif/frtic_timer_test.sv ***
// self-checking bench for the free-running timer with input capture
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module frtic_timer_test
    import frtic_pkg::*;
;
    logic             sys_clk = 1'b0;
    logic             rstn    = 1'b0;
    logic             rd      = 1'b0;
    logic             wr      = 1'b0;
    logic [7:0]       addr    = 8'h00;
    logic [31:0]      wdata   = 32'h0;
    logic [3:0]       be      = 4'hf;
    logic [31:0]      rdata, v, c0, c1;
    logic             wreq, shout, shoe_n, shin, irq;
    logic [2:0]       cpins;
    logic [NFLAG-1:0] irqv;
    int               fails   = 0;
    int               n_tests = 0;
    // prescale setting beside the counter step expected over 320 clocks
    logic [17:0]      rows[4] = '{{2'h0, 16'h00a0}, {2'h1, 16'h0028},
                                  {2'h2, 16'h0014}, {2'h3, 16'h000a}};
    // 50 ns clock
    always #25 sys_clk = ~sys_clk;
    // design and pin-side model
    frtic_timer u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .capture_pin_in(cpins),
        .shared_channel_pin_in(shin), .shared_channel_pin_out(shout),
        .shared_channel_pin_oe_n(shoe_n), .irq_vector(irqv), .irq(irq));
    frtic_pin_model u_pins (
        .sys_clk(sys_clk), .pin_out(shout), .pin_oe_n(shoe_n),
        .cap_pins(cpins), .shared_in(shin));
    // verdict and end of run
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // one bus access, held until waitrequest is seen low; data lands in v
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b = 4'hf);
        int k;
        @(posedge sys_clk);
        {rd, wr, addr, wdata, be} <= {!w, w, a, d, b};
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (wreq === 1'b0) break;
        end
        if (wreq !== 1'b0) begin fails++; tally_and_finish(); end
        v = rdata;
        {rd, wr} <= 2'b00;
    endtask : bus
    // poll the flag register until the wanted bits show
    task automatic wait_flag(input logic [NFLAG-1:0] m);
        int k;
        for (k = 0; k < 30; k++) begin
            bus(1'b0, OFF_FLAG, 32'h0);
            if ((v[NFLAG-1:0] & m) === m) break;
        end
        if (k == 30) begin fails++; tally_and_finish(); end
    endtask : wait_flag
    // six clocks of reset
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask : do_reset
    // main sequence
    initial begin
        do_reset();
        // each prescale; a counter write in between must change nothing
        foreach (rows[i]) begin
            bus(1'b1, OFF_PULSE_ACCUM_CONTROL_REG, {30'h0, rows[i][17:16]});
            bus(1'b0, OFF_COUNT, 32'h0);
            c0 = v;
            bus(1'b1, OFF_COUNT, 32'h0000_fff0);
            repeat (314) @(posedge sys_clk);
            bus(1'b0, OFF_COUNT, 32'h0);
            `CHK(v[15:0] - c0[15:0], rows[i][15:0])
        end
        // ch1 rising, ch2 falling, ch3 either edge, all unmasked
        bus(1'b1, OFF_PULSE_ACCUM_CONTROL_REG, 32'h0);
        bus(1'b1, OFF_EDGE, 32'h0000_0039);
        bus(1'b1, OFF_MASK, 32'h0000_000f);
        bus(1'b0, OFF_COUNT, 32'h0);
        c0 = v;
        u_pins.drive(4'h7);
        wait_flag(10'h005);
        `CHK(v[NFLAG-1:0], 10'h005)
        `CHK(irqv, 10'h005)
        `CHK(irq, 1'b1)
        bus(1'b0, OFF_CAPT, 32'h0);
        c1 = v;
        `CHK(c1[15:0] - c0[15:0] < 16'h0008, 1'b1)
        bus(1'b0, OFF_CAPT + 8'h08, 32'h0);
        `CHK(v, c1)
        // clear by writing ones, then falling edges
        bus(1'b1, OFF_FLAG, 32'h0000_03ff);
        bus(1'b0, OFF_FLAG, 32'h0);
        `CHK(v, 32'h0)
        `CHK(irq, 1'b0)
        u_pins.drive(4'h0);
        wait_flag(10'h006);
        `CHK(v[NFLAG-1:0], 10'h006)
        bus(1'b0, OFF_CAPT, 32'h0);
        `CHK(v, c1)
        // all edge pairs off: no capture
        bus(1'b1, OFF_EDGE, 32'h0);
        bus(1'b1, OFF_FLAG, 32'h0000_03ff);
        u_pins.drive(4'h7);
        repeat (12) @(posedge sys_clk);
        bus(1'b0, OFF_FLAG, 32'h0);
        `CHK(v, 32'h0)
        // high-byte reads right after an edge delay the capture only
        bus(1'b1, OFF_EDGE, 32'h0000_0001);
        u_pins.drive(4'h0);
        bus(1'b1, OFF_FLAG, 32'h0000_03ff);
        u_pins.drive(4'h1);
        repeat (3) bus(1'b0, OFF_CAPT, 32'h0, 4'h2);
        wait_flag(10'h001);
        bus(1'b0, OFF_CAPT, 32'h0);
        c1 = v;
        // shared register is compare five until select is set
        bus(1'b1, OFF_CAPT + 8'h0c, 32'h0000_1234);
        bus(1'b0, OFF_CAPT + 8'h0c, 32'h0);
        `CHK(v[15:0], 16'h1234)
        bus(1'b1, OFF_PULSE_ACCUM_CONTROL_REG, 32'h0000_0004);
        bus(1'b1, OFF_CAPT + 8'h0c, 32'h0000_5555);
        bus(1'b0, OFF_CAPT + 8'h0c, 32'h0);
        `CHK(v[15:0], 16'h1234)
        // shared pin as output: a written rising edge captures, masked
        bus(1'b1, OFF_EDGE, 32'h0000_0040);
        bus(1'b1, OFF_MASK, 32'h0000_0007);
        bus(1'b1, OFF_FLAG, 32'h0000_03ff);
        bus(1'b1, OFF_PULSE_ACCUM_CONTROL_REG, 32'h0000_000c);
        bus(1'b1, OFF_PORT, 32'h0000_0008);
        `CHK(shoe_n, 1'b0)
        wait_flag(10'h008);
        `CHK(irq, 1'b0)
        bus(1'b0, OFF_PORT, 32'h0);
        `CHK(v[3:0], 4'h9)
        // compare five owns the pin: port write ignored
        bus(1'b1, OFF_PULSE_ACCUM_CONTROL_REG, 32'h0000_0008);
        bus(1'b1, OFF_PORT, 32'h0);
        bus(1'b0, OFF_PORT, 32'h0);
        `CHK(shout, 1'b1)
        // second reset: counter restarts, captures keep their contents
        do_reset();
        `CHK(shoe_n, 1'b1)
        bus(1'b0, OFF_COUNT, 32'h0);
        `CHK(v[15:4], 12'h000)
        bus(1'b0, OFF_CAPT, 32'h0);
        `CHK(v, c1)
        bus(1'b0, OFF_PULSE_ACCUM_CONTROL_REG, 32'h0);
        `CHK(v, 32'h0)
        bus(1'b0, 8'hf0, 32'h0);
        `CHK(v, 32'h0)
        tally_and_finish();
    end
endmodule : frtic_timer_test
`default_nettype wire
